// ### hdl/dlv_video_out.sv
`timescale 1ns/1ps
// Functional notes
// R01 - Two, four or eight output taps selectable
// R02 - Sample widths of 8, 10, 12 bits
// R03 - Only supported tap/width combinations are accepted
// R04 - Frame valid rises only on a B line
// R05 - Each B line is followed by A line
// R06 - Frame valid lasts an even programmed line count
// R07 - Zero line count keeps frame valid low
// R08 - Pixel bits placed on ports per tap mode
// R09 - Valid flags and clock fixed in every mode
// R10 - Full line is the model pixel count
// R11 - Region width replaces full width when set
// R12 - Controller should start exposures by line trigger
// R13 - Controller should use programmed exposure duration; there is no duration register, sens_start is a one-cycle pulse
// R14 - Line A buffered, sent three triggers later
// R15 - Odd triggers expose and send B, even send A
// R16 - First B and A after enable are junk
// R17 - Line and data valid span all beats
module dlv_video_out #(
  parameter int MODEL_PIXELS = 4096,
  parameter bit SUPPORT_4TAP = 1'b1,
  parameter bit SUPPORT_8TAP = 1'b1
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic [31:0]                     hrdata,
  output logic                            hresp,
  input  wire logic                       line_trigger,
  input  wire logic                       pix_clk,
  output logic                            sens_start,
  input  wire logic                       sens_valid,
  input  wire logic [11:0]                sens_a,
  input  wire logic [11:0]                sens_b,
  output logic                            vid_fval,
  output logic                            vid_lval,
  output logic                            vid_dval,
  output logic [dlv_pkg::VID_W-1:0]       vid_data
);
  localparam int PW = $clog2(MODEL_PIXELS);
  localparam int LW = PW + 1;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [dlv_pkg::SYNC_W-1:0] sync_w;
  logic                       pix_prev_q;
  logic                       trig_prev_q;
  logic                       pix_rise;
  logic                       trig_rise;

  dlv_sync #(.W(dlv_pkg::SYNC_W)) u_sync (
    .clk  (sys_clk),
    .rst  (rst),
    .din  ({pix_clk, line_trigger}),
    .dout (sync_w)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pix_prev_q  <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      pix_prev_q  <= sync_w[1];
      trig_prev_q <= sync_w[0];
    end
  end

  assign pix_rise  = sync_w[1] & ~pix_prev_q;
  assign trig_rise = sync_w[0] & ~trig_prev_q;

  // ----------------------------------------------------------------
  // AHB-Lite slave and registers
  // ----------------------------------------------------------------
  logic        en_q, en_prev_q, rej_q;
  logic [1:0]  tap_q, depth_q;
  logic [15:0] fval_len_q, roi_q, frame_cnt_q;
  logic        ahb_wr_q;
  logic [7:0]  ahb_addr_q;
  logic        phase_q, first_pair_q, cap_busy_q;
  dlv_pkg::dlv_tx_t state_q;

  logic        ahb_take, ahb_hit, busy_w;
  logic [1:0]  new_tap, new_depth;
  logic        new_ok, wr_ctrl, wr_fval, wr_roi;
  logic [31:0] rd_val_w;

  assign ahb_take  = hsel & htrans[1] & hready;
  assign ahb_hit   = (haddr[31:4] == 28'h0);
  assign busy_w    = cap_busy_q | (state_q != dlv_pkg::TX_IDLE);
  assign new_tap   = hwdata[dlv_pkg::CTRL_TAP_LSB +: 2];
  assign new_depth = hwdata[dlv_pkg::CTRL_DEPTH_LSB +: 2];
  assign new_ok    = dlv_pkg::combo_ok(new_tap, new_depth,
                                       SUPPORT_4TAP, SUPPORT_8TAP);
  assign wr_ctrl   = ahb_wr_q & (ahb_addr_q == dlv_pkg::REG_CTRL);
  assign wr_fval   = ahb_wr_q & (ahb_addr_q == dlv_pkg::REG_FVAL);
  assign wr_roi    = ahb_wr_q & (ahb_addr_q == dlv_pkg::REG_ROI);
  assign rd_val_w  =
    !ahb_hit ? 32'h0 :
    (haddr[7:0] == dlv_pkg::REG_CTRL) ? {27'h0, depth_q, tap_q, en_q} :
    (haddr[7:0] == dlv_pkg::REG_FVAL) ? {16'h0, fval_len_q} :
    (haddr[7:0] == dlv_pkg::REG_ROI)  ? {16'h0, roi_q} :
    (haddr[7:0] == dlv_pkg::REG_STATUS) ?
      {frame_cnt_q, 10'h0, first_pair_q, cap_busy_q, rej_q,
       vid_fval, phase_q, busy_w} : 32'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ahb_wr_q   <= 1'b0;
      ahb_addr_q <= 8'h0;
      hrdata     <= 32'h0;
      hreadyout  <= 1'b0;
      hresp      <= 1'b0;
    end else begin
      hreadyout  <= 1'b1;
      ahb_wr_q   <= ahb_take & hwrite & ahb_hit;
      ahb_addr_q <= haddr[7:0];
      if (ahb_take && !hwrite) begin
        hrdata <= rd_val_w;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_q       <= 1'b0;
      tap_q      <= dlv_pkg::TAP_2;
      depth_q    <= dlv_pkg::DEPTH_8;
      rej_q      <= 1'b0;
      fval_len_q <= dlv_pkg::FVAL_LEN_RST;
      roi_q      <= dlv_pkg::ROI_RST;
      en_prev_q  <= 1'b0;
    end else begin
      en_prev_q <= en_q;
      if (wr_ctrl) begin
        en_q  <= hwdata[dlv_pkg::CTRL_EN_BIT];
        rej_q <= ~new_ok;
        if (new_ok) begin // see R01, R02, R03
          tap_q   <= new_tap;
          depth_q <= new_depth;
        end
      end
      if (wr_fval) begin
        fval_len_q <= {hwdata[15:1], 1'b0}; // see R06
      end
      if (wr_roi) begin
        roi_q <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Line length and tap geometry
  // ----------------------------------------------------------------
  logic [LW-1:0] len_w, n_beats_w;
  logic [3:0]    tap_n;
  logic [1:0]    tap_sh;

  assign tap_n  = dlv_pkg::tap_num(tap_q);
  assign tap_sh = dlv_pkg::tap_log2(tap_q);
  // Zero or oversize region falls back to the full sensor
  assign len_w  = (roi_q == 16'h0 || roi_q > 16'(MODEL_PIXELS)) ?
                  LW'(MODEL_PIXELS) : LW'(roi_q); // see R10, R11
  assign n_beats_w = (len_w + LW'(tap_n) - LW'(1)) >> tap_sh; // see R17

  // ----------------------------------------------------------------
  // Trigger sequencing and sensor capture
  // ----------------------------------------------------------------
  logic          idle_w, en_rise, go_exp, go_a, cap_last;
  logic [LW-1:0] cap_idx_q;
  logic          wr_bank_q;

  assign idle_w   = en_q & ~busy_w;
  assign en_rise  = en_q & ~en_prev_q;
  assign go_exp   = idle_w & trig_rise & ~phase_q; // see R15
  assign go_a     = idle_w & trig_rise & phase_q;  // see R15
  assign cap_last = cap_busy_q & sens_valid &
                    (cap_idx_q == len_w - LW'(1));

  // A trigger that lands while a line is busy is dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_q      <= 1'b0;
      wr_bank_q    <= 1'b0;
      first_pair_q <= 1'b0;
      cap_busy_q   <= 1'b0;
      cap_idx_q    <= '0;
      sens_start   <= 1'b0;
    end else begin
      sens_start <= go_exp;
      if (en_rise) begin
        phase_q      <= 1'b0;
        wr_bank_q    <= 1'b0;
        first_pair_q <= 1'b1; // see R16
      end else if (go_exp) begin
        phase_q <= 1'b1;
      end else if (go_a) begin
        phase_q      <= 1'b0;
        first_pair_q <= 1'b0;
      end
      if (go_exp) begin
        cap_busy_q <= 1'b1;
        cap_idx_q  <= '0;
      end else if (cap_last) begin
        cap_busy_q <= 1'b0;
        wr_bank_q  <= ~wr_bank_q; // see R14
      end else if (cap_busy_q && sens_valid) begin
        cap_idx_q <= cap_idx_q + LW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Line buffers: B single bank, A ping-pong over two exposures
  // ----------------------------------------------------------------
  logic [LW-1:0] rd_idx_w, fbeat_q, fetch_beat, beat_q;
  logic [3:0]    fcnt_q, fetch_slot;
  logic [11:0]   a_rd, b_rd, pix_val;
  logic          tx_b_q, tx_bank_q, present_w, fetching, line_end;
  logic [11:0]   shadow_q [dlv_pkg::MAX_TAPS];

  dlv_lbuf #(.DW(dlv_pkg::SAMPLE_W), .AW(PW)) u_buf_b (
    .clk     (sys_clk),
    .wr_en   (cap_busy_q & sens_valid),
    .wr_addr (cap_idx_q[PW-1:0]),
    .wr_data (sens_b),
    .rd_addr (rd_idx_w[PW-1:0]),
    .rd_data (b_rd)
  );

  dlv_lbuf #(.DW(dlv_pkg::SAMPLE_W), .AW(PW + 1)) u_buf_a (
    .clk     (sys_clk),
    .wr_en   (cap_busy_q & sens_valid),
    .wr_addr ({wr_bank_q, cap_idx_q[PW-1:0]}),
    .wr_data (sens_a),
    .rd_addr ({tx_bank_q, rd_idx_w[PW-1:0]}),
    .rd_data (a_rd)
  );

  // ----------------------------------------------------------------
  // Transmit engine
  // ----------------------------------------------------------------
  // Taps for the next beat are gathered one per cycle while the
  // current beat is on the link, so a beat needs tap_n system clocks.
  assign present_w  = pix_rise & ((state_q == dlv_pkg::TX_WAIT) |
                      ((state_q == dlv_pkg::TX_RUN) &
                       (beat_q != n_beats_w)));
  assign line_end   = pix_rise & (state_q == dlv_pkg::TX_RUN) &
                      (beat_q == n_beats_w);
  assign fetch_slot = present_w ? 4'h0 : fcnt_q;
  assign fetch_beat = present_w ? fbeat_q + LW'(1) : fbeat_q;
  assign fetching   = present_w | ((fcnt_q < tap_n) &
                      (state_q != dlv_pkg::TX_IDLE));
  assign rd_idx_w   = LW'(fetch_beat << tap_sh) + LW'(fetch_slot);
  assign pix_val    = (rd_idx_w >= len_w) ? 12'h0 :
                      dlv_pkg::fmt_sample(tx_b_q ? b_rd : a_rd,
                                          depth_q); // see R02

  logic [dlv_pkg::VID_W-1:0] vid_pack_w;
  for (genvar t = 0; t < dlv_pkg::MAX_TAPS; t++) begin : g_tap
    assign vid_pack_w[t*dlv_pkg::SAMPLE_W +: dlv_pkg::SAMPLE_W] =
      (4'(t) < tap_n) ? shadow_q[t] : 12'h0; // see R01, R08
  end

  always_ff @(posedge sys_clk) begin
    if (fetching) begin
      shadow_q[fetch_slot[2:0]] <= pix_val;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q   <= dlv_pkg::TX_IDLE;
      tx_b_q    <= 1'b0;
      tx_bank_q <= 1'b0;
      fbeat_q   <= '0;
      fcnt_q    <= 4'h0;
      beat_q    <= '0;
    end else begin
      if (fetching) begin
        fcnt_q  <= fetch_slot + 4'h1;
        fbeat_q <= fetch_beat;
      end
      case (state_q)
        dlv_pkg::TX_IDLE: begin
          if (cap_last || go_a) begin
            state_q   <= dlv_pkg::TX_PRIME;
            tx_b_q    <= cap_last;  // see R05, R15
            tx_bank_q <= wr_bank_q; // see R14
            fbeat_q   <= '0;
            fcnt_q    <= 4'h0;
          end
        end
        dlv_pkg::TX_PRIME: begin
          if (fcnt_q >= tap_n) begin
            state_q <= dlv_pkg::TX_WAIT;
          end
        end
        dlv_pkg::TX_WAIT: begin
          if (present_w) begin
            state_q <= dlv_pkg::TX_RUN;
            beat_q  <= LW'(1);
          end
        end
        dlv_pkg::TX_RUN: begin
          if (line_end) begin
            state_q <= dlv_pkg::TX_IDLE;
          end else if (present_w) begin
            beat_q <= beat_q + LW'(1);
          end
        end
        default: state_q <= dlv_pkg::TX_IDLE;
      endcase
    end
  end

  // Flags keep their own ports in every tap mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vid_lval    <= 1'b0;
      vid_dval    <= 1'b0;
      vid_data    <= '0;
      vid_fval    <= 1'b0;
      frame_cnt_q <= 16'h0;
    end else begin
      if (present_w) begin
        vid_lval <= 1'b1; // see R09, R17
        vid_dval <= 1'b1; // see R17
        vid_data <= vid_pack_w;
      end else if (line_end) begin
        vid_lval <= 1'b0;
        vid_dval <= 1'b0;
        vid_data <= '0;
      end
      if (fval_len_q == 16'h0) begin
        vid_fval    <= 1'b0; // see R07
        frame_cnt_q <= 16'h0;
      end else if (present_w && state_q == dlv_pkg::TX_WAIT &&
                   tx_b_q && !vid_fval) begin
        vid_fval <= 1'b1; // see R04
      end else if (line_end && vid_fval) begin
        if (frame_cnt_q + 16'h1 >= fval_len_q) begin
          vid_fval    <= 1'b0; // see R06
          frame_cnt_q <= 16'h0;
        end else begin
          frame_cnt_q <= frame_cnt_q + 16'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [LW-1:0] lval_beats_q;
  logic          last_b_q;
  always_ff @(posedge sys_clk) begin
    if (rst || !vid_lval) begin
      lval_beats_q <= '0;
    end else if (pix_rise) begin
      lval_beats_q <= lval_beats_q + LW'(1);
    end
    if (rst) begin
      last_b_q <= 1'b0;
    end else if (en_rise) begin
      last_b_q <= 1'b0;
    end else if (cap_last || go_a) begin
      last_b_q <= cap_last;
    end
  end

  a_fval_zero_len: assert property ( // see R07
    (fval_len_q == 16'h0)[*2] |-> !vid_fval)
    else $error("frame valid high with zero length");
  a_lval_dval_pair: assert property (vid_lval == vid_dval) // see R17
    else $error("line valid and data valid differ");
  a_fval_b_line: assert property ( // see R04
    $rose(vid_fval) |-> $rose(vid_lval) && tx_b_q)
    else $error("frame valid rose off a B line start");
  a_line_beats: assert property ( // see R10, R11, R17
    $fell(vid_lval) |-> lval_beats_q == n_beats_w)
    else $error("line beat count wrong");
  a_b_then_a: assert property ( // see R05
    (state_q == dlv_pkg::TX_IDLE && (cap_last || go_a) && last_b_q)
      |-> !cap_last)
    else $error("B line not followed by A line");
  a_fval_even: assert property ( // see R06
    $fell(vid_fval) && fval_len_q != 16'h0 |->
      ($past(frame_cnt_q) + 16'h1 == fval_len_q) && !fval_len_q[0])
    else $error("frame valid length not honoured");
  a_cfg_legal: assert property ( // see R03
    dlv_pkg::combo_ok(tap_q, depth_q, SUPPORT_4TAP, SUPPORT_8TAP))
    else $error("unsupported tap and depth combination");
  a_a_bank_old: assert property ( // see R14, R15
    go_a |=> tx_bank_q == wr_bank_q && !tx_b_q && !phase_q)
    else $error("A line read from wrong bank");
  a_unused_taps: assert property ( // see R01, R08
    (tap_q == dlv_pkg::TAP_2) && $stable(tap_q) |=>
      vid_data[dlv_pkg::VID_W-1:24] == '0)
    else $error("data on unused tap");
  a_lval_on_beat: assert property ( // see R09
    $changed(vid_lval) |-> $past(pix_rise))
    else $error("line valid moved off a pixel clock edge");

  c_frame_start: cover property ($rose(vid_fval));
  c_a_line: cover property (go_a ##[1:1000] $rose(vid_lval));
  c_eight_tap: cover property (tap_q == dlv_pkg::TAP_8 && vid_lval);
  c_reject: cover property (wr_ctrl && !new_ok);
endmodule

// ### hdl/dlv_pkg.sv
package dlv_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_FVAL   = 8'h04;
  localparam logic [7:0] REG_ROI    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_TAP_LSB   = 1;
  localparam int CTRL_DEPTH_LSB = 3;

  localparam logic [15:0] FVAL_LEN_RST = 16'h0000;
  localparam logic [15:0] ROI_RST      = 16'h0000;

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TAP_2    = 2'h0;
  localparam logic [1:0] TAP_4    = 2'h1;
  localparam logic [1:0] TAP_8    = 2'h2;
  localparam logic [1:0] DEPTH_8  = 2'h0;
  localparam logic [1:0] DEPTH_10 = 2'h1;
  localparam logic [1:0] DEPTH_12 = 2'h2;

  localparam int SAMPLE_W = 12;
  localparam int MAX_TAPS = 8;
  localparam int VID_W    = MAX_TAPS * SAMPLE_W;
  localparam int SYNC_W   = 2;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_PRIME,
    TX_WAIT,
    TX_RUN
  } dlv_tx_t;

  function automatic logic [3:0] tap_num(input logic [1:0] code);
    case (code)
      TAP_4:   tap_num = 4'h4;
      TAP_8:   tap_num = 4'h8;
      default: tap_num = 4'h2;
    endcase
  endfunction

  function automatic logic [1:0] tap_log2(input logic [1:0] code);
    case (code)
      TAP_4:   tap_log2 = 2'h2;
      TAP_8:   tap_log2 = 2'h3;
      default: tap_log2 = 2'h1;
    endcase
  endfunction

  // Eight taps at wide samples would overrun the link, so only 8 bit
  function automatic logic combo_ok(input logic [1:0] tap,
                                    input logic [1:0] depth,
                                    input logic       sup4,
                                    input logic       sup8);
    logic ok;
    ok = (depth != 2'h3);
    case (tap)
      TAP_2:   combo_ok = ok;
      TAP_4:   combo_ok = ok && sup4;
      TAP_8:   combo_ok = ok && sup8 && (depth == DEPTH_8);
      default: combo_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [11:0] fmt_sample(input logic [11:0] s,
                                             input logic [1:0]  depth);
    case (depth)
      DEPTH_8:  fmt_sample = {4'h0, s[11:4]};
      DEPTH_10: fmt_sample = {2'h0, s[11:2]};
      default:  fmt_sample = s;
    endcase
  endfunction

endpackage

// ### hdl/dlv_sync.sv
`timescale 1ns/1ps
module dlv_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ### hdl/dlv_lbuf.sv
`timescale 1ns/1ps
module dlv_lbuf #(
  parameter int DW = 12,
  parameter int AW = 12
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  // Read is asynchronous so a tap can be gathered every cycle
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule

// ### sim/dlv_fg_model.sv
`timescale 1ns/1ps
module dlv_fg_model (
  input  wire logic                      fire,
  input  wire logic [3:0]                taps,
  input  wire logic                      vid_fval,
  input  wire logic                      vid_lval,
  input  wire logic                      vid_dval,
  input  wire logic [dlv_pkg::VID_W-1:0] vid_data,
  output logic                           line_trigger,
  output logic                           pix_clk,
  output int                             line_cnt,
  output int                             beats,
  output logic                           gap_fval,
  output logic                           head_fval,
  output logic                           flag_err,
  output logic [11:0]                    px [16]
);
  logic run_q;
  logic in_line;
  int   n;
  initial begin
    line_trigger = 1'b0;
    pix_clk = 1'b0;
    run_q = 1'b0;
    in_line = 1'b0;
    flag_err = 1'b0;
    line_cnt = 0;
  end
  // --------------------------------
  // Trigger and pixel clock
  // --------------------------------
  // Pulse 200 ns high, then at least 2 us low before the next one
  // Pins move 5 ns after the bench edge so no flop samples a change
  always @(posedge fire) begin
    #5;
    run_q = 1'b1;
    line_trigger = 1'b1;
    #200;
    line_trigger = 1'b0;
    #2000;
  end
  // Clock stands still between lines, so no stray beats appear
  always begin
    wait (run_q);
    #80 pix_clk = 1'b1;
    #80 pix_clk = 1'b0;
  end
  always @(posedge pix_clk) begin
    if (vid_dval !== vid_lval) flag_err = 1'b1;
    if (vid_lval === 1'b1) begin
      if (!in_line) head_fval = vid_fval;
      if (!in_line) n = 0;
      in_line = 1'b1;
      for (int t = 0; t < 8; t++) begin
        if (t >= taps && vid_data[t*12 +: 12] !== 12'h000) flag_err = 1'b1;
        else if (t < taps && n * taps + t < 16) px[n*taps+t] = vid_data[t*12 +: 12];
      end
      n++;
    end else if (in_line) begin
      in_line = 1'b0;
      beats = n;
      gap_fval = vid_fval;
      run_q = 1'b0;
      line_cnt++;
    end
  end
endmodule

// ### sim/tb_dual_line_pair_video_output.sv
`timescale 1ns/1ps
module tb_dual_line_pair_video_output;
  localparam logic [31:0] A_CTRL = {24'h0, dlv_pkg::REG_CTRL};
  localparam logic [31:0] A_FVAL = {24'h0, dlv_pkg::REG_FVAL};
  localparam logic [31:0] A_ROI  = {24'h0, dlv_pkg::REG_ROI};
  localparam logic [31:0] A_STAT = {24'h0, dlv_pkg::REG_STATUS};
  logic        sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, sens_start, vid_fval, vid_lval, vid_dval;
  logic        sens_valid = 1'b0, fire = 1'b0, line_trigger, pix_clk;
  logic [11:0] sens_a = 12'h000, sens_b = 12'h000;
  logic [3:0]  taps = 4'h2;
  logic        gap_fval, head_fval, flag_err;
  logic [11:0] px [16];
  logic [dlv_pkg::VID_W-1:0] vid_data;
  int          bad_count = 0, num_checks = 0, line_cnt, beats;
  int          exp_no = 0, len = 16;
  wire         hready = hreadyout;

  dlv_video_out #(.MODEL_PIXELS(16)) uut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .line_trigger(line_trigger), .pix_clk(pix_clk),
    .sens_start(sens_start), .sens_valid(sens_valid), .sens_a(sens_a),
    .sens_b(sens_b), .vid_fval(vid_fval), .vid_lval(vid_lval),
    .vid_dval(vid_dval), .vid_data(vid_data)
  );
  dlv_fg_model fg (
    .fire(fire), .taps(taps), .vid_fval(vid_fval), .vid_lval(vid_lval),
    .vid_dval(vid_dval), .vid_data(vid_data),
    .line_trigger(line_trigger), .pix_clk(pix_clk), .line_cnt(line_cnt),
    .beats(beats), .gap_fval(gap_fval), .head_fval(head_fval),
    .flag_err(flag_err), .px(px)
  );

  always #10 sys_clk = ~sys_clk;

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic stop_test();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want,
                     input string what);
    num_checks++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, want);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  function automatic logic [11:0] want_px(int n, int i, logic [1:0] dc);
    logic [11:0] s;
    if (n % 2 == 1) s = {4'hb, 4'((n + 1) / 2), 4'(i)};
    else s = {4'ha, 4'(n / 2 - 1), 4'(i)};
    if (i >= len) s = 12'h000;
    if (dc == dlv_pkg::DEPTH_8) s = s >> 4;
    if (dc == dlv_pkg::DEPTH_10) s = s >> 2;
    return s;
  endfunction

  // Junk lines 1 and 2 are checked for framing only
  task automatic run_mode(logic [1:0] tc, logic [1:0] dc, logic [31:0] fl,
                          logic [31:0] roi, int lines);
    int base;
    int nb;
    ahb(1'b1, A_CTRL, 32'h0);
    ahb(1'b1, A_FVAL, fl);
    ahb(1'b1, A_ROI, roi);
    taps <= 4'h2 << tc;
    len = (roi == 0 || roi > 16) ? 16 : roi;
    exp_no = 0;
    ahb(1'b1, A_CTRL, {27'h0, dc, tc, 1'b1});
    ahb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h20, "first pair");
    nb = (len + (2 << tc) - 1) / (2 << tc);
    base = line_cnt;
    for (int n = 1; n <= lines; n++) begin
      @(posedge sys_clk);
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      for (int k = 0; k < 3000 && line_cnt != base + n; k++)
        @(posedge sys_clk);
      chk(32'(line_cnt - base), 32'(n), "lines");
      chk(32'(beats), 32'(nb), "beats");
      chk({31'h0, head_fval}, 32'(fl != 0), "fval head");
      chk({31'h0, gap_fval}, 32'(fl != 0 && n % fl != 0), "fval end");
      for (int i = 0; i < nb * (2 << tc) && n > 2; i++)
        chk({20'h0, px[i]}, {20'h0, want_px(n, i, dc)}, "pixel");
      repeat (120) @(posedge sys_clk);
    end
  endtask

  // --------------------------------
  // Sensor and main sequence
  // --------------------------------
  // Samples between strobes are inverted so stale data cannot pass
  initial forever begin
    @(posedge sys_clk);
    if (sens_start === 1'b1) begin
      exp_no++;
      for (int i = 0; i < len; i++) begin
        @(posedge sys_clk);
        sens_valid <= 1'b1;
        sens_b <= {4'hb, 4'(exp_no), 4'(i)};
        sens_a <= {4'ha, 4'(exp_no), 4'(i)};
        @(posedge sys_clk);
        sens_valid <= 1'b0;
        sens_b <= ~sens_b;
        sens_a <= ~sens_a;
      end
    end
  end

  initial begin
    #1000000;
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    ahb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    ahb(1'b0, A_FVAL, 32'h0);
    chk(rd, 32'h0, "fval reset");
    ahb(1'b0, A_ROI, 32'h0);
    chk(rd, 32'h0, "roi reset");
    ahb(1'b1, 32'h100, 32'hffff);
    ahb(1'b0, 32'h100, 32'h0);
    chk(rd, 32'h0, "unmapped");
    ahb(1'b1, A_FVAL, 32'h3);
    ahb(1'b0, A_FVAL, 32'h0);
    chk(rd, 32'h2, "odd fval");
    run_mode(dlv_pkg::TAP_2, dlv_pkg::DEPTH_12, 32'h4, 32'h0, 8);
    run_mode(dlv_pkg::TAP_4, dlv_pkg::DEPTH_10, 32'h2, 32'h6, 4);
    ahb(1'b1, A_CTRL, {27'h0, dlv_pkg::DEPTH_10, dlv_pkg::TAP_8, 1'b0});
    ahb(1'b0, A_CTRL, 32'h0);
    chk(rd, {27'h0, dlv_pkg::DEPTH_10, dlv_pkg::TAP_4, 1'b0}, "kept");
    ahb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h8, "reject flag");
    chk({31'h0, hresp}, 32'h0, "response");
    run_mode(dlv_pkg::TAP_8, dlv_pkg::DEPTH_8, 32'h0, 32'h14, 4);
    chk({31'h0, flag_err}, 32'h0, "flags and idle taps");
    stop_test();
  end
endmodule
